// ---- src/cis_pkg.sv ----
// Constants and types shared by the interrupt sequencer block.
package cis_pkg;

  // ****************************************************************
  // Vector table addresses.
  // ****************************************************************
  localparam logic [15:0] VEC_RESET    = 16'h3FFE;
  localparam logic [15:0] VEC_SWTRAP   = 16'h3FFC;
  localparam logic [15:0] VEC_EXT      = 16'h3FFA;
  localparam logic [15:0] VEC_WTIMER   = 16'h3FF8;
  localparam logic [15:0] VEC_LINK     = 16'h3FF6;
  localparam logic [15:0] VEC_SERIAL   = 16'h3FF4;
  localparam logic [15:0] VEC_NTIMER   = 16'h3FF2;

  // ****************************************************************
  // Timing and reset values.
  // ****************************************************************
  localparam int          STACK_CYCLES = 10;
  localparam logic [3:0]  STACK_LAST   = 4'(STACK_CYCLES - 1);
  localparam logic        RST_MASK     = 1'b1;
  localparam logic        RST_PIN_EN   = 1'b1;
  localparam logic        RST_PORT_EN  = 1'b0;
  localparam logic        RST_FLAG     = 1'b0;
  localparam logic [7:0]  PORT_IDLE    = 8'hFF;

  // ****************************************************************
  // Sequencer states.
  // ****************************************************************
  typedef enum logic [4:0]
  {
    ST_RESET = 5'b0_0001,
    ST_RUN   = 5'b0_0010,
    ST_STACK = 5'b0_0100,
    ST_VECT  = 5'b0_1000,
    ST_PULL  = 5'b1_0000
  } cis_state_type;

endpackage : cis_pkg

// ---- src/cis_sequencer.sv ----
// Interrupt sequencer with the combined external interrupt logic.
//
// What this block does
// RL1: Requests never abort an instruction; they wait for instruction end.
// RL2: Hardware service starts only with mask clear and source enabled.
// RL3: Finish instruction, stack registers, set mask, then pick the source.
// RL4: Highest vector wins: external, wide timer, link, serial, narrow timer.
// RL5: Vectors lie from 3FF2 to 3FFF, two bytes per source.
// RL6: Latency is longest instruction plus ten stacking cycles at most.
// RL7: Return pulls registers and resumes the interrupted instruction stream.
// RL8: Reset loads the start vector 3FFE and sets the mask.
// RL9: Software trap is taken regardless of mask, vector 3FFC.
// RL10: Trap follows earlier pending requests, precedes later ones.
// RL11: All hardware sources except reset are blocked while mask is set.
// RL12: Pin, port A and port C each latch, merged into one request.
// RL13: Port groups AND their input pins; a falling edge sets the flag.
// RL14: Unused input pins of those ports must be held high externally.
// RL15: Build option picks edge only or edge plus low level on the pin.
// RL16: In level mode a sustained low also sets the pin flag.
// RL17: Each external flag is gated by its own enable.
// RL18: The external request vectors through 3FFA.
// RL19: Entering external service clears the pin latch, not port flags.
// RL20: Acknowledge write clears all three external latches.
// RL21: Port flags are read only and acknowledge reads zero.
// RL22: Software should not shift the control register.
// RL23: Pin enable is set by reset and by stop or wait; gates pin flag.
// RL24: Reset clears port enables and flags; stop and wait keep them.
// RL25: External inputs are synchronised before edge detection.
`timescale 1ns/1ps

module cis_sequencer
#(
  parameter bit LEVEL_MODE = 1'b0
)
(
  // Clock and reset.
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  // Internal reset request from other blocks.
  input  wire logic                   i_int_rst,
  // External pins, asynchronous.
  input  wire logic                   i_req_pin_b,
  input  wire logic [7:0]             i_porta,
  input  wire logic [7:0]             i_portc,
  input  wire logic [7:0]             i_porta_is_in,
  input  wire logic [7:0]             i_portc_is_in,
  // Internal peripheral requests, already flag and enable qualified.
  input  wire logic                   i_wtimer_req,
  input  wire logic                   i_link_req,
  input  wire logic                   i_serial_req,
  input  wire logic                   i_ntimer_req,
  // Core handshake.
  input  wire logic                   i_instr_done,
  input  wire logic                   i_swtrap_fetch,
  input  wire logic                   i_return_fetch,
  input  wire logic                   i_mask_clear,
  input  wire logic                   i_mask_set,
  input  wire logic                   i_stop_wait,
  // Software control writes of the external control register.
  input  wire logic                   i_ctrl_wr,
  input  wire logic                   i_wr_pin_en,
  input  wire logic                   i_wr_porta_en,
  input  wire logic                   i_wr_portc_en,
  input  wire logic                   i_wr_ack,
  // Sequencer outputs to the core.
  output logic                        o_stack_go,
  output logic                        o_pull_go,
  output logic                        o_vector_go,
  output logic [15:0]                 o_vector_addr,
  output logic                        o_mask,
  // External control and status bits, read view.
  output logic                        o_pin_request_flag,
  output logic                        o_porta_request_flag,
  output logic                        o_portc_request_flag,
  output logic                        o_pin_request_enable,
  output logic                        o_porta_request_enable,
  output logic                        o_portc_request_enable,
  output logic                        o_ext_request_ack,
  output logic                        o_ext_request
);
  import cis_pkg::*;

  // ****************************************************************
  // State record.
  // ****************************************************************
  typedef struct packed
  {
    cis_state_type st;
    logic [3:0]    cnt;
    logic          trap;
    logic          trap_first;
    logic          mask;
    logic          pin_flag;
    logic          pa_flag;
    logic          pc_flag;
    logic          pin_en;
    logic          pa_en;
    logic          pc_en;
    logic [2:0]    pin_sy;
    logic [2:0]    pa_sy;
    logic [2:0]    pc_sy;
    logic          pin_old;
    logic          pa_old;
    logic          pc_old;
    logic          stack_go;
    logic          pull_go;
    logic          vector_go;
    logic [15:0]   vector;
  } cis_regs_type;

  cis_regs_type r;
  cis_regs_type next_r;

  // Port groups: AND of the input-configured pins, output pins read high.
  logic          pa_and;
  logic          pc_and;
  logic          pin_now;
  logic          pa_now;
  logic          pc_now;
  logic          pin_fall;
  logic          pa_fall;
  logic          pc_fall;
  logic          ext_req;
  logic          hw_req;

  // Unused input pins must idle high or they mask other edges.
  assign pa_and = &(i_porta | ~i_porta_is_in);  // see RL13, see RL14
  assign pc_and = &(i_portc | ~i_portc_is_in);  // see RL13

  // A change is accepted once the second and third stages agree.
  assign pin_now  = (r.pin_sy[1] == r.pin_sy[2]) ? r.pin_sy[2] : r.pin_old;
  assign pa_now   = (r.pa_sy[1] == r.pa_sy[2]) ? r.pa_sy[2] : r.pa_old;
  assign pc_now   = (r.pc_sy[1] == r.pc_sy[2]) ? r.pc_sy[2] : r.pc_old;
  assign pin_fall = r.pin_old & ~pin_now;  // see RL25
  assign pa_fall  = r.pa_old & ~pa_now;
  assign pc_fall  = r.pc_old & ~pc_now;

  // Three latches merge into one external request, each under its enable.
  assign ext_req = (r.pin_flag & r.pin_en) | (r.pa_flag & r.pa_en)
                 | (r.pc_flag & r.pc_en);  // see RL12, see RL17
  // Peripheral requests arrive already qualified by their own enables.
  assign hw_req  = ext_req | i_wtimer_req | i_link_req | i_serial_req
                 | i_ntimer_req;  // see RL2

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb
  begin
    next_r           = r;
    next_r.stack_go  = 1'b0;
    next_r.pull_go   = 1'b0;
    next_r.vector_go = 1'b0;

    // Synchronisers; stage zero feeds only stage one.
    next_r.pin_sy  = {r.pin_sy[1:0], i_req_pin_b};  // see RL25
    next_r.pa_sy   = {r.pa_sy[1:0], pa_and};
    next_r.pc_sy   = {r.pc_sy[1:0], pc_and};
    next_r.pin_old = pin_now;
    next_r.pa_old  = pa_now;
    next_r.pc_old  = pc_now;

    // Mask control from the core instructions.
    if (i_mask_clear || i_stop_wait)
    begin
      next_r.mask = 1'b0;
    end
    else if (i_mask_set)
    begin
      next_r.mask = 1'b1;
    end

    // Enable bits written by software; stop and wait force the pin enable.
    if (i_ctrl_wr)
    begin
      next_r.pin_en = i_wr_pin_en;
      next_r.pa_en  = i_wr_porta_en;
      next_r.pc_en  = i_wr_portc_en;
    end
    if (i_stop_wait)
    begin
      next_r.pin_en = 1'b1;  // see RL23, see RL24
    end

    // Acknowledge clears all latches; port flags ignore writes.
    if (i_ctrl_wr && i_wr_ack)
    begin
      next_r.pin_flag = 1'b0;  // see RL20, see RL21
      next_r.pa_flag  = 1'b0;
      next_r.pc_flag  = 1'b0;
    end

    // Sequencer.
    case (r.st)
      ST_RESET:
      begin
        next_r.mask      = 1'b1;  // see RL8
        next_r.vector    = VEC_RESET;
        next_r.vector_go = 1'b1;
        next_r.st        = ST_RUN;
      end
      ST_RUN:
      begin
        // Decisions happen only at an instruction boundary.
        if (i_instr_done)  // see RL1
        begin
          if (i_swtrap_fetch)
          begin
            // Trap ignores the mask but yields to earlier requests.
            next_r.trap       = 1'b1;  // see RL9
            next_r.trap_first = ~(hw_req & ~r.mask);  // see RL10
            next_r.cnt        = '0;
            next_r.stack_go   = 1'b1;
            next_r.st         = ST_STACK;
          end
          else if (i_return_fetch)
          begin
            next_r.pull_go = 1'b1;  // see RL7
            next_r.st      = ST_PULL;
          end
          else if (hw_req && !r.mask)  // see RL2, see RL11
          begin
            next_r.trap     = 1'b0;
            next_r.cnt      = '0;
            next_r.stack_go = 1'b1;  // see RL3
            next_r.st       = ST_STACK;
          end
        end
      end
      ST_STACK:
      begin
        // Bounded stacking window before the vector is chosen.
        if (r.cnt == STACK_LAST)  // see RL6
        begin
          next_r.mask = 1'b1;  // see RL3
          next_r.st   = ST_VECT;
        end
        else
        begin
          next_r.cnt = r.cnt + 4'h1;
        end
      end
      ST_VECT:
      begin
        next_r.vector_go = 1'b1;
        next_r.trap      = 1'b0;
        next_r.st        = ST_RUN;
        // Earlier pending hardware requests are served before the trap.
        if (r.trap && (r.trap_first || !hw_req))
        begin
          next_r.vector = VEC_SWTRAP;  // see RL9, see RL10
        end
        else if (ext_req)  // see RL4
        begin
          next_r.vector   = VEC_EXT;  // see RL18
          next_r.pin_flag = 1'b0;  // see RL19
        end
        else if (i_wtimer_req)
        begin
          next_r.vector = VEC_WTIMER;  // see RL5
        end
        else if (i_link_req)
        begin
          next_r.vector = VEC_LINK;
        end
        else if (i_serial_req)
        begin
          next_r.vector = VEC_SERIAL;
        end
        else
        begin
          next_r.vector = VEC_NTIMER;
        end
      end
      ST_PULL:
      begin
        // The core restores the saved mask with the other registers.
        next_r.st = ST_RUN;  // see RL7
      end
      default:
      begin
        next_r.st = ST_RESET;
      end
    endcase

    // Flags set after the acknowledge and vector clears so a new event wins over them.
    if (pa_fall)
    begin
      next_r.pa_flag = 1'b1;  // see RL13
    end
    if (pc_fall)
    begin
      next_r.pc_flag = 1'b1;
    end
    // Pin flag only sets while enabled; level mode adds the low state.
    if (r.pin_en && (pin_fall || (LEVEL_MODE && !pin_now)))
    begin
      next_r.pin_flag = 1'b1;  // see RL15, see RL16, see RL23
    end

    if (i_int_rst)
    begin
      next_r.st       = ST_RESET;  // see RL8
      next_r.mask     = RST_MASK;
      next_r.pin_en   = RST_PIN_EN;
      next_r.pa_en    = RST_PORT_EN;  // see RL24
      next_r.pc_en    = RST_PORT_EN;
      next_r.pin_flag = RST_FLAG;
      next_r.pa_flag  = RST_FLAG;
      next_r.pc_flag  = RST_FLAG;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      r            <= '0;
      r.st         <= ST_RESET;
      r.mask       <= RST_MASK;
      r.pin_en     <= RST_PIN_EN;  // see RL23
      r.pa_en      <= RST_PORT_EN;
      r.pc_en      <= RST_PORT_EN;
      r.pin_sy     <= 3'b111;
      r.pa_sy      <= 3'b111;
      r.pc_sy      <= 3'b111;
      r.pin_old    <= 1'b1;
      r.pa_old     <= 1'b1;
      r.pc_old     <= 1'b1;
      r.vector     <= VEC_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs straight from the state record; ack is tied low and the request is the merged flags.
  assign o_stack_go             = r.stack_go;
  assign o_pull_go              = r.pull_go;
  assign o_vector_go            = r.vector_go;
  assign o_vector_addr          = r.vector;
  assign o_mask                 = r.mask;
  assign o_pin_request_flag     = r.pin_flag;
  assign o_porta_request_flag   = r.pa_flag;
  assign o_portc_request_flag   = r.pc_flag;
  assign o_pin_request_enable   = r.pin_en;
  assign o_porta_request_enable = r.pa_en;
  assign o_portc_request_enable = r.pc_en;
  assign o_ext_request_ack      = 1'b0;  // see RL21
  assign o_ext_request          = ext_req;

endmodule : cis_sequencer

// ---- verification/cis_sequencer_assertions.sv ----
// Checker for the interrupt sequencer port behaviour.
`timescale 1ns/1ps

module cis_sequencer_assertions
(
  // Clock, reset and core inputs.
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_int_rst,
  input wire logic        i_instr_done,
  input wire logic        i_swtrap_fetch,
  input wire logic        i_mask_clear,
  input wire logic        i_stop_wait,
  input wire logic        i_ctrl_wr,
  input wire logic        i_wr_ack,
  // Outputs watched.
  input wire logic        o_stack_go,
  input wire logic        o_vector_go,
  input wire logic [15:0] o_vector_addr,
  input wire logic        o_mask,
  input wire logic        o_pin_request_flag,
  input wire logic        o_porta_request_flag,
  input wire logic        o_portc_request_flag,
  input wire logic        o_pin_request_enable,
  input wire logic        o_porta_request_enable,
  input wire logic        o_portc_request_enable,
  input wire logic        o_ext_request_ack,
  input wire logic        o_ext_request
);
  import cis_pkg::*;

  // All checks share one clock; reset silences them.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_take; o_stack_go |-> $past(i_instr_done); endproperty
  a_take: assert property (p_take) else $error("stack off boundary");
  property p_lat; o_stack_go |-> ##[10:11] o_vector_go; endproperty
  a_lat: assert property (p_lat) else $error("vector late");
  property p_mask; o_vector_go |-> o_mask; endproperty
  a_mask: assert property (p_mask) else $error("mask clear at vector");
  property p_blk;
    o_mask && !i_mask_clear && i_instr_done && !i_swtrap_fetch
      |=> !o_stack_go;
  endproperty
  a_blk: assert property (p_blk) else $error("masked request taken");
  property p_ack;
    i_ctrl_wr && i_wr_ack |=> !(o_pin_request_flag
      || o_porta_request_flag || o_portc_request_flag);
  endproperty
  a_ack: assert property (p_ack) else $error("ack left a flag");
  property p_ro;
    $fell(o_porta_request_flag) || $fell(o_portc_request_flag)
      |-> $past((i_ctrl_wr && i_wr_ack) || i_int_rst);
  endproperty
  a_ro: assert property (p_ro) else $error("port flag lost");
  property p_zero; !o_ext_request_ack; endproperty
  a_zero: assert property (p_zero) else $error("ack reads one");
  property p_merge;
    o_ext_request == ((o_pin_request_flag && o_pin_request_enable)
      || (o_porta_request_flag && o_porta_request_enable)
      || (o_portc_request_flag && o_portc_request_enable));
  endproperty
  a_merge: assert property (p_merge) else $error("merge wrong");
  property p_ext;
    o_vector_go && o_vector_addr == VEC_EXT |-> ##[0:1] !o_pin_request_flag;
  endproperty
  a_ext: assert property (p_ext) else $error("pin flag kept");
  property p_stop; i_stop_wait |=> o_pin_request_enable && !o_mask;
  endproperty
  a_stop: assert property (p_stop) else $error("stop or wait");
endmodule : cis_sequencer_assertions

bind cis_sequencer cis_sequencer_assertions i_chk (
  .i_clk                  (i_clk),
  .i_rst_b                (i_rst_b),
  .i_int_rst              (i_int_rst),
  .i_instr_done           (i_instr_done),
  .i_swtrap_fetch         (i_swtrap_fetch),
  .i_mask_clear           (i_mask_clear),
  .i_stop_wait            (i_stop_wait),
  .i_ctrl_wr              (i_ctrl_wr),
  .i_wr_ack               (i_wr_ack),
  .o_stack_go             (o_stack_go),
  .o_vector_go            (o_vector_go),
  .o_vector_addr          (o_vector_addr),
  .o_mask                 (o_mask),
  .o_pin_request_flag     (o_pin_request_flag),
  .o_porta_request_flag   (o_porta_request_flag),
  .o_portc_request_flag   (o_portc_request_flag),
  .o_pin_request_enable   (o_pin_request_enable),
  .o_porta_request_enable (o_porta_request_enable),
  .o_portc_request_enable (o_portc_request_enable),
  .o_ext_request_ack      (o_ext_request_ack),
  .o_ext_request          (o_ext_request)
);

// ---- verification/cis_core_model.sv ----
// Behavioural core model that issues instruction boundaries.
`timescale 1ns/1ps

module cis_core_model
(
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Instruction length and kind of the next instruction.
  input  wire logic [3:0] i_gap,
  input  wire logic [1:0] i_kind,
  // Sequencer answers.
  input  wire logic       i_stack_go,
  input  wire logic       i_pull_go,
  input  wire logic       i_vector_go,
  // Boundary outputs.
  output logic            o_instr_done,
  output logic            o_swtrap_fetch,
  output logic            o_return_fetch
);
  logic [3:0] cnt;
  logic       busy;

  // A boundary comes only after a whole instruction; stacking stalls it.
  always_ff @(negedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      {cnt, busy, o_instr_done, o_swtrap_fetch, o_return_fetch} <= '0;
    end
    else
    begin
      {o_instr_done, o_swtrap_fetch, o_return_fetch} <= 3'h0;
      if (i_stack_go)
        busy <= 1'b1;
      else if (i_vector_go || i_pull_go)
        {busy, cnt} <= 5'h00;
      else if (!busy && cnt >= i_gap)
      begin
        cnt <= 4'h0;
        busy <= i_kind != 2'h0;
        {o_instr_done, o_swtrap_fetch, o_return_fetch} <= {1'b1, i_kind};
      end
      else if (!busy)
        cnt <= cnt + 4'h1;
    end
  end
endmodule : cis_core_model

// ---- verification/tb_cis_sequencer.sv ----
// Self-checking testbench for the interrupt sequencer.
`timescale 1ns/1ps

module tb_cis_sequencer;
  import cis_pkg::*;
  logic        clk, rst_b, pin_b, mclr, stopw, wr, wpin, wpa, wpc, wack;
  logic [7:0]  pa, pc, pa_in, pc_in, m;
  logic [3:0]  req, gap;
  logic [1:0]  kind;
  logic        done, trap, ret, stk, pul, vgo, msk, ext, ack;
  logic        fpin, fpa, fpc, epin, epa, epc;
  logic        irst, lfpin, lext;
  logic [15:0] vad;
  logic [15:0] expq[$];
  int          failures, check_count, k;

  cis_sequencer #(.LEVEL_MODE(1'b0)) i_dut (.i_clk(clk), .i_rst_b(rst_b),
    .i_int_rst(irst), .i_req_pin_b(pin_b), .i_porta(pa), .i_portc(pc),
    .i_porta_is_in(pa_in), .i_portc_is_in(pc_in), .i_wtimer_req(req[3]),
    .i_link_req(req[2]), .i_serial_req(req[1]), .i_ntimer_req(req[0]),
    .i_instr_done(done), .i_swtrap_fetch(trap), .i_return_fetch(ret),
    .i_mask_clear(mclr), .i_mask_set(1'b0), .i_stop_wait(stopw),
    .i_ctrl_wr(wr), .i_wr_pin_en(wpin), .i_wr_porta_en(wpa),
    .i_wr_portc_en(wpc), .i_wr_ack(wack), .o_stack_go(stk),
    .o_pull_go(pul), .o_vector_go(vgo), .o_vector_addr(vad), .o_mask(msk),
    .o_pin_request_flag(fpin), .o_porta_request_flag(fpa),
    .o_portc_request_flag(fpc), .o_pin_request_enable(epin),
    .o_porta_request_enable(epa), .o_portc_request_enable(epc),
    .o_ext_request_ack(ack), .o_ext_request(ext));

  // A level-mode copy shares pins and writes but never sequences.
  cis_sequencer #(.LEVEL_MODE(1'b1)) i_dut_lvl (.i_clk(clk),
    .i_rst_b(rst_b), .i_int_rst(irst), .i_req_pin_b(pin_b),
    .i_porta(pa), .i_portc(pc), .i_porta_is_in(pa_in),
    .i_portc_is_in(pc_in), .i_wtimer_req(1'b0), .i_link_req(1'b0),
    .i_serial_req(1'b0), .i_ntimer_req(1'b0), .i_instr_done(1'b0),
    .i_swtrap_fetch(1'b0), .i_return_fetch(1'b0), .i_mask_clear(mclr),
    .i_mask_set(1'b0), .i_stop_wait(stopw), .i_ctrl_wr(wr),
    .i_wr_pin_en(wpin), .i_wr_porta_en(wpa), .i_wr_portc_en(wpc),
    .i_wr_ack(wack), .o_stack_go(), .o_pull_go(), .o_vector_go(),
    .o_vector_addr(), .o_mask(), .o_pin_request_flag(lfpin),
    .o_porta_request_flag(), .o_portc_request_flag(),
    .o_pin_request_enable(), .o_porta_request_enable(),
    .o_portc_request_enable(), .o_ext_request_ack(),
    .o_ext_request(lext));

  cis_core_model i_core (.i_clk(clk), .i_rst_b(rst_b), .i_gap(gap),
    .i_kind(kind), .i_stack_go(stk), .i_pull_go(pul), .i_vector_go(vgo),
    .o_instr_done(done), .o_swtrap_fetch(trap), .o_return_fetch(ret));

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  task automatic chk_bit(logic got, logic exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t bit %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_vec(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t vector %h, expected %h", $time, got, exp);
    end
  endtask : chk_vec

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // Waits, bounded, until every noted vector has been seen.
  task automatic wait_res();
    int n;
    n = 0;
    while (expq.size() != 0 && n < 300)
    begin
      cyc(1);
      n++;
    end
    if (n == 300)
    begin
      failures++;
      $display("[ERR] %0t no vector", $time);
    end
  endtask : wait_res

  task automatic serve(logic [15:0] exp);
    expq.push_back(exp);
    mclr = 1'b1;
    cyc(1);
    mclr = 1'b0;
    wait_res();
  endtask : serve

  task automatic ctl(logic p, logic a, logic c, logic k);
    // Every bit is written explicitly, never shifted into place.
    {wpin, wpa, wpc, wack, wr} = {p, a, c, k, 1'b1};
    cyc(1);
    wr = 1'b0;
    cyc(2);
  endtask : ctl

  // Every vector or return pull is matched to the oldest note.
  always @(negedge clk)
    if (vgo || pul)
    begin
      if (expq.size() == 0)
      begin
        failures++;
        $display("[ERR] %0t unexpected vector", $time);
      end
      else
        chk_vec(pul ? 16'h0000 : vad, expq.pop_front());
    end

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The limit of 20000 clock periods is many times the expected run length.
  initial
  begin
    #(50 * 20000);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    {irst, rst_b, mclr, stopw, wr, wpin, wpa, wpc, wack, kind, req} = '0;
    {pin_b, pa, pc, pa_in, pc_in, gap} = {17'h1_FFFF, 16'h0000, 4'h3};
    {failures, check_count, k} = '0;
    void'($urandom(46));
    expq.push_back(VEC_RESET);
    cyc(4);
    rst_b = 1'b1;
    wait_res();
    chk_bit(msk & epin, 1'b1);
    chk_bit(epa | epc | fpa | fpc | fpin, 1'b0);
    chk_bit(ack, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      {req, gap} = {4'($urandom_range(1, 15)), 4'($urandom_range(2, 9))};
      cyc(12);
      for (int b = 0; b < 4; b++)
        if (req[b]) k = b;
      serve(VEC_NTIMER + 16'(2 * k));
      req = 4'h0;
    end
    $display("test priority done");
    // The model's kind: bit one marks a trap, bit zero a return.
    kind = 2'd2;
    expq.push_back(VEC_SWTRAP);
    wait_res();
    kind = 2'd1;
    expq.push_back(16'h0000);
    wait_res();
    // A request pending at the trap boundary is served before the trap.
    {req, kind} = {4'h1, 2'd2};
    expq.push_back(VEC_NTIMER);
    serve(VEC_SWTRAP);
    {req, kind} = 6'h00;
    $display("test trap and return done");
    pin_b = 1'b0;
    cyc(8);
    chk_bit(fpin & ext, 1'b1);
    serve(VEC_EXT);
    chk_bit(fpin, 1'b0);
    pin_b = 1'b1;
    ctl(1'b1, 1'b1, 1'b1, 1'b0);
    for (int p = 0; p < 2; p++)
    begin
      m = 8'($urandom) | 8'h01;
      {pa_in, pc_in} = {m, m};
      cyc(4);
      if (p == 0) pa = m; else pc = m;
      cyc(8);
      chk_bit(fpa | fpc, 1'b0);
      if (p == 0) pa = 8'h00; else pc = 8'h00;
      cyc(8);
      chk_bit((p == 0 ? fpa : fpc) & ext, 1'b1);
      serve(VEC_EXT);
      chk_bit(p == 0 ? fpa : fpc, 1'b1);
      ctl(1'b1, 1'b0, 1'b0, 1'b0);
      chk_bit(p == 0 ? fpa : fpc, 1'b1);
      ctl(1'b1, 1'b1, 1'b1, 1'b1);
      chk_bit(fpa | fpc, 1'b0);
      {pa, pc} = 16'hFFFF;
    end
    $display("test ports done");
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    pin_b = 1'b0;
    cyc(8);
    chk_bit(fpin | lfpin, 1'b0);
    stopw = 1'b1;
    cyc(1);
    stopw = 1'b0;
    cyc(1);
    chk_bit(epin & ~msk, 1'b1);
    chk_bit(epa & ~epc, 1'b1);
    chk_bit(lfpin & lext & ~fpin, 1'b1);
    pin_b = 1'b1;
    cyc(4);
    $display("test stop and wait done");
    expq.push_back(VEC_RESET);
    irst = 1'b1;
    cyc(1);
    irst = 1'b0;
    wait_res();
    chk_bit(msk & epin, 1'b1);
    chk_bit(epa | epc | fpa | fpc | lfpin, 1'b0);
    $display("test internal reset done");
    complete_run();
  end
endmodule : tb_cis_sequencer
